/* File: hw/wpd_pkg.sv */
// shared constants, types and register map of the wake pin detector
`default_nettype none
package wpd_pkg;
    // clock and filter timing
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned FILTER_TIME_NS = 10000;
    // least time, so round up to whole cycles
    localparam int unsigned FILT_CYCLES = (FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [11:0] FILT_COUNT = 12'(FILT_CYCLES);

    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_LEVEL = 4'h4;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'hc;

    // field positions
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned LEVEL_BIT = 0;

    // reset values
    localparam logic CTRL_ENABLE_RESET = 1'b0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // rise in bit 0, fall in bit 1 (status, mask, events)
    typedef struct packed {
        logic fall;
        logic rise;
    } wpd_pair_t;

    // operating mode of the surrounding chip
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_INIT = 3'b001,
        MODE_NORMAL = 3'b010,
        MODE_STOP = 3'b011,
        MODE_SLEEP = 3'b100,
        MODE_RESTART = 3'b101,
        MODE_FAILSAFE = 3'b110,
        MODE_SWFLASH = 3'b111
    } wpd_mode_t;

    // sleep wake tracker
    typedef enum logic [1:0] {
        WST_ACTIVE = 2'b00,
        WST_SLEEP = 2'b01,
        WST_WOKEN = 2'b10
    } wpd_wst_t;
endpackage
`default_nettype wire

/* File: hw/wpd_wake_filter.sv */
// wake input synchroniser and both-edge glitch filter
`timescale 1ns/10ps
`default_nettype none
module wpd_wake_filter (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic wake_input,
    input wire logic hold_off,
    output logic level,
    output wpd_pkg::wpd_pair_t edges
);
    logic sync_a;
    logic sync_b;
    logic stable;
    logic [11:0] cnt;

    // two-flop synchroniser, first stage feeds only the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else if (ce) begin
            sync_a <= wake_input;
            sync_b <= sync_a;
        end
    end

    // counter runs while level differs, any bounce back restarts it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stable <= 1'b0;
            cnt <= 12'h000;
            edges <= '0;
        end else if (ce) begin
            edges <= '0;
            if (hold_off) begin
                // track silently so recovery raises no stale event
                stable <= sync_b;
                cnt <= 12'h000;
            end else if (sync_b == stable) begin
                cnt <= 12'h000;
            end else if (cnt == wpd_pkg::FILT_COUNT) begin
                stable <= sync_b;
                cnt <= 12'h000;
                edges.rise <= sync_b;
                edges.fall <= ~sync_b;
            end else begin
                cnt <= cnt + 12'h001;
            end
        end
    end

    assign level = stable;

    a_uv_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        ce && hold_off |=> !edges.rise && !edges.fall) else $error("event under undervoltage");
    a_filter_span: assert property (@(posedge clk_sys) disable iff (rst)
        $past(ce) && (edges.rise || edges.fall) |-> $past(cnt) == wpd_pkg::FILT_COUNT
        && $past(sync_b) != $past(stable)) else $error("edge before filter time");
    a_edge_dir: assert property (@(posedge clk_sys) disable iff (rst)
        (edges.rise |-> stable) and (edges.fall |-> !stable)) else $error("edge direction wrong");
    a_bounce_restart: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !hold_off && sync_b == stable |=> cnt == 12'h000) else $error("filter not restarted");
endmodule
`default_nettype wire

/* File: hw/wpd_edge_flags.sv */
// sticky edge flags with write-one-to-clear and mask
`timescale 1ns/10ps
`default_nettype none
module wpd_edge_flags (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic set_en,
    input wire wpd_pkg::wpd_pair_t edges,
    input wire wpd_pkg::wpd_pair_t clr,
    input wire wpd_pkg::wpd_pair_t mask,
    output wpd_pkg::wpd_pair_t flags,
    output logic irq
);
    // set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else if (ce) begin
            flags <= wpd_pkg::wpd_pair_t'((flags & ~clr) | (edges & {2{set_en}}));
        end
    end

    // mask bit high blocks that edge from the output
    assign irq = |(flags & ~mask);

    a_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
        ce && set_en && edges.rise |=> flags.rise) else $error("rise flag lost");
    a_fall_set: assert property (@(posedge clk_sys) disable iff (rst)
        ce && set_en && edges.fall |=> flags.fall && irq == !mask.fall || flags.rise && !mask.rise)
        else $error("fall flag lost");
    a_mask_split: assert property (@(posedge clk_sys) disable iff (rst)
        flags.rise && !flags.fall && mask.rise |-> !irq) else $error("masked rise raised irq");
endmodule
`default_nettype wire

/* File: hw/wpd_wake_pin_detector.sv */
// wake pin detector top: avalon registers, sleep wake and restart requests
// Functional notes
// - falling and rising wake input transitions both count as wake events.
// - a new level counts only after it persists longer than the filter time.
// - software enables or disables the wake function by a register bit.
// - below the undervoltage threshold all wake events are ignored.
// - wake level is readable in normal, stop and software flash modes.
// - with enable set, a valid edge ends sleep mode.
// - in fail-safe mode any valid edge requests restart mode.
// - with enable in active modes each edge sets its flag, interrupt unless masked.
// - rising and falling interrupts are masked independently.
// - pending flags at or during sleep entry cause an immediate wake.
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module wpd_wake_pin_detector (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic wake_input,
    input wire logic uv_off,
    input wire wpd_pkg::wpd_mode_t sbc_mode,
    input wire logic sleep_transition,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic wake_from_sleep,
    output logic restart_request
);
    logic level;
    wpd_pkg::wpd_pair_t edges;
    wpd_pkg::wpd_pair_t flags;
    wpd_pkg::wpd_pair_t mask;
    wpd_pkg::wpd_pair_t clr;
    logic wake_function_enable;
    logic ack;
    logic req;
    logic wr_stb;
    logic set_en;
    logic any_edge;
    logic any_flag;
    wpd_pkg::wpd_wst_t state;
    wpd_pkg::wpd_wst_t next_state;
    logic next_wake;
    logic next_restart;

    // modes in which level is visible and flags may be set
    function automatic logic mode_active(input wpd_pkg::wpd_mode_t m);
        return (m == wpd_pkg::MODE_NORMAL) || (m == wpd_pkg::MODE_STOP) || (m == wpd_pkg::MODE_SWFLASH);
    endfunction

    // register read multiplexer, unmapped offsets read zero
    function automatic logic [31:0] read_word(
        input logic [3:0] a,
        input logic en,
        input logic lvl,
        input wpd_pkg::wpd_pair_t f,
        input wpd_pkg::wpd_pair_t m
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            wpd_pkg::REG_CTRL: w[wpd_pkg::CTRL_ENABLE_BIT] = en;
            wpd_pkg::REG_LEVEL: w[wpd_pkg::LEVEL_BIT] = lvl;
            wpd_pkg::REG_IRQ_STATUS: w[1:0] = f;
            wpd_pkg::REG_IRQ_MASK: w[1:0] = m;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    wpd_wake_filter u_filter (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .wake_input(wake_input),
        .hold_off(uv_off),
        .level(level),
        .edges(edges)
    );

    // flags set only when enabled, in active modes or during the sleep handover
    assign set_en = wake_function_enable && !uv_off && (mode_active(sbc_mode) || sleep_transition);

    wpd_edge_flags u_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set_en(set_en),
        .edges(edges),
        .clr(clr),
        .mask(mask),
        .flags(flags),
        .irq(irq)
    );

    assign any_edge = edges.rise || edges.fall;
    assign any_flag = flags.rise || flags.fall;

    // one wait state per access; readdata is loaded while waitrequest is high
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack;
    assign wr_stb = avs_write && ack;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else if (ce) begin
            ack <= req && !ack;
        end
    end

    // read data captured one edge before the answer edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (ce && avs_read && !ack) begin
            avs_readdata <= read_word(avs_address, wake_function_enable,
                                      level && mode_active(sbc_mode), flags, mask);
        end
    end

    // enable bit, only byte lane 0 carries fields
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wake_function_enable <= wpd_pkg::CTRL_ENABLE_RESET;
        end else if (ce && wr_stb && avs_address == wpd_pkg::REG_CTRL && avs_byteenable[0]) begin
            wake_function_enable <= avs_writedata[wpd_pkg::CTRL_ENABLE_BIT];
        end
    end

    // independent mask bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mask <= wpd_pkg::wpd_pair_t'(wpd_pkg::IRQ_MASK_RESET);
        end else if (ce && wr_stb && avs_address == wpd_pkg::REG_IRQ_MASK && avs_byteenable[0]) begin
            mask <= wpd_pkg::wpd_pair_t'(avs_writedata[1:0]);
        end
    end

    // write-one-to-clear strobe toward the flags
    always_comb begin
        clr = '0;
        if (wr_stb && avs_address == wpd_pkg::REG_IRQ_STATUS && avs_byteenable[0]) begin
            clr = wpd_pkg::wpd_pair_t'(avs_writedata[1:0]);
        end
    end

    // sleep tracker: pending flags are not cleared by sleep entry, so they wake at once;
    // software is expected to clear them before commanding sleep
    always_comb begin
        next_state = state;
        next_wake = 1'b0;
        unique case (state)
            wpd_pkg::WST_ACTIVE: begin
                if (sbc_mode == wpd_pkg::MODE_SLEEP) begin
                    next_state = wpd_pkg::WST_SLEEP;
                end
            end
            wpd_pkg::WST_SLEEP: begin
                if (sbc_mode != wpd_pkg::MODE_SLEEP) begin
                    next_state = wpd_pkg::WST_ACTIVE;
                end else if (any_flag || (wake_function_enable && any_edge)) begin
                    next_state = wpd_pkg::WST_WOKEN;
                    next_wake = 1'b1;
                end
            end
            wpd_pkg::WST_WOKEN: begin
                if (sbc_mode != wpd_pkg::MODE_SLEEP) begin
                    next_state = wpd_pkg::WST_ACTIVE;
                end
            end
            default: next_state = wpd_pkg::WST_ACTIVE;
        endcase
    end

    // fail-safe restart ignores the enable bit
    assign next_restart = (sbc_mode == wpd_pkg::MODE_FAILSAFE) && any_edge;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= wpd_pkg::WST_ACTIVE;
            wake_from_sleep <= 1'b0;
            restart_request <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            wake_from_sleep <= next_wake;
            restart_request <= next_restart;
        end
    end

    a_sleep_flag_wake: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state == wpd_pkg::WST_SLEEP && sbc_mode == wpd_pkg::MODE_SLEEP && any_flag
        |=> wake_from_sleep && state == wpd_pkg::WST_WOKEN) else $error("pending flag did not wake");
    a_sleep_edge_wake: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state == wpd_pkg::WST_SLEEP && sbc_mode == wpd_pkg::MODE_SLEEP && wake_function_enable
        && any_edge |=> wake_from_sleep) else $error("edge did not end sleep");
    a_wake_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $past(ce) && wake_from_sleep |-> $past(state) == wpd_pkg::WST_SLEEP) else $error("spurious wake");
    a_failsafe_restart: assert property (@(posedge clk_sys) disable iff (rst)
        ce && sbc_mode == wpd_pkg::MODE_FAILSAFE && any_edge |=> restart_request) else $error("no restart");
    a_disable_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !wake_function_enable && !any_flag |=> !flags.rise && !flags.fall) else $error("flag while off");
    a_level_read: assert property (@(posedge clk_sys) disable iff (rst)
        ce && avs_read && !ack && avs_address == wpd_pkg::REG_LEVEL
        |=> avs_readdata[0] == ($past(level) && $past(mode_active(sbc_mode)))) else $error("bad level read");
    a_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
        ce && avs_waitrequest |=> !avs_waitrequest || !req) else $error("waitrequest held too long");
    a_uv_no_flag: assert property (@(posedge clk_sys) disable iff (rst)
        ce && uv_off && !any_flag |=> !flags.rise && !flags.fall) else $error("flag under undervoltage");
    a_mode_gate: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !mode_active(sbc_mode) && !sleep_transition && !any_flag |=> !flags.rise && !flags.fall)
        else $error("flag outside active modes");
    a_irq_unmasked: assert property (@(posedge clk_sys) disable iff (rst)
        (flags.rise && !mask.rise) || (flags.fall && !mask.fall) |-> irq)
        else $error("unmasked flag without irq");
    a_restart_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $past(ce) && restart_request |-> $past(sbc_mode) == wpd_pkg::MODE_FAILSAFE)
        else $error("restart outside fail-safe");
    a_ce_freeze: assert property (@(posedge clk_sys) disable iff (rst)
        !ce |=> $stable(flags) && $stable(mask) && $stable(wake_function_enable))
        else $error("state moved while frozen");
endmodule
`default_nettype wire

/* File: verification/wpd_switch_model.sv */
// behavioural wake switch on the wake pin, with optional short bounce
`timescale 1ns/10ps
`default_nettype none
module wpd_switch_model (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic set_level,
    input wire logic [11:0] bounce_len,
    output var logic wake_input
);
    logic back;
    logic [11:0] cnt;
    initial begin
        wake_input = 1'b0;
        back = 1'b0;
        cnt = 12'h0;
    end
    // nonzero length gives a pulse that falls back to the old level
    always @(posedge clk_sys) begin
        if (start) begin
            back <= wake_input;
            wake_input <= set_level;
            cnt <= bounce_len;
        end else if (cnt != 12'h0) begin
            cnt <= cnt - 12'h1;
            if (cnt == 12'h1) begin
                wake_input <= back; // end of the disturbance
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_wake_pin_detector.sv */
// self-checking bench for the wake pin detector
`timescale 1ns/10ps
`default_nettype none
module tb_wake_pin_detector;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic uv_off = 1'b0;
    wpd_pkg::wpd_mode_t sbc_mode = wpd_pkg::MODE_INIT;
    logic sleep_transition = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic wake_from_sleep;
    logic restart_request;
    logic wake_input;
    logic sw_start = 1'b0;
    logic sw_level = 1'b0;
    logic [11:0] sw_len = 12'h0;
    int fail_count = 0;
    int checked = 0;
    int seed = 32'hb9e3;
    logic [31:0] rnd;
    logic [31:0] rd_q[$];
    logic [1:0] pulse_q[$];

    always #2.5 clk_sys = ~clk_sys;

    wpd_wake_pin_detector u_wpd_wake_pin_detector (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .wake_input(wake_input), .uv_off(uv_off), .sbc_mode(sbc_mode), .sleep_transition(sleep_transition),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .wake_from_sleep(wake_from_sleep), .restart_request(restart_request));
    wpd_switch_model u_wpd_switch_model (.clk_sys(clk_sys), .start(sw_start), .set_level(sw_level),
        .bounce_len(sw_len), .wake_input(wake_input));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("counts: %0d compared, %0d wrong", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one access; the request is held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        // waitrequest is read at the rising edge, before that edge updates it
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            end_sim();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask

    // irq is combinational, so look at it mid-cycle
    task automatic chk_irq(input logic exp);
        @(negedge clk_sys);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    // pin change, then the fixed sync plus filter latency
    task automatic pin(input logic lvl, input logic [11:0] len);
        @(posedge clk_sys);
        sw_level <= lvl;
        sw_len <= len;
        sw_start <= 1'b1;
        @(posedge clk_sys);
        sw_start <= 1'b0;
        repeat (wpd_pkg::FILT_CYCLES + 8) @(posedge clk_sys);
    endtask

    task automatic setm(input wpd_pkg::wpd_mode_t m);
        @(posedge clk_sys);
        sbc_mode <= m;
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask

    // read data taken at the same edge at which waitrequest is seen low
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (rd_q.size() == 0) begin
                chk(avs_readdata, 32'hffff_ffff);
            end else begin
                chk(avs_readdata, rd_q.pop_front());
            end
        end
    end

    // one-cycle pulses looked at mid-cycle, while they stand
    always @(negedge clk_sys) begin
        if (wake_from_sleep === 1'b1 || restart_request === 1'b1) begin
            if (pulse_q.size() == 0) begin
                chk({30'h0, restart_request, wake_from_sleep}, 32'h0);
            end else begin
                chk({30'h0, restart_request, wake_from_sleep}, {30'h0, pulse_q.pop_front()});
            end
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values and refused accesses
        rd(wpd_pkg::REG_CTRL, 32'h0);
        rd(wpd_pkg::REG_IRQ_MASK, 32'h0);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h0);
        bus(1'b1, 4'h1, 32'h1, 4'h1);
        bus(1'b1, wpd_pkg::REG_CTRL, 32'h1, 4'h0);
        rd(wpd_pkg::REG_CTRL, 32'h0);
        rd(4'h1, 32'h0);
        tdone("reset");
        // both edges, glitch rejection, masks and clearing
        setm(wpd_pkg::MODE_NORMAL);
        wr(wpd_pkg::REG_CTRL, 32'h1);
        rd(wpd_pkg::REG_CTRL, 32'h1);
        pin(1'b1, 12'h0);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h1);
        chk_irq(1'b1);
        rnd = $random(seed);
        pin(1'b0, 12'h1 + (rnd[11:0] & 12'h3ff));
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h1);
        rd(wpd_pkg::REG_LEVEL, 32'h1);
        pin(1'b0, 12'h0);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h3);
        wr(wpd_pkg::REG_IRQ_MASK, 32'h2);
        chk_irq(1'b1);
        wr(wpd_pkg::REG_IRQ_MASK, 32'h3);
        chk_irq(1'b0);
        wr(wpd_pkg::REG_IRQ_STATUS, 32'h1);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h2);
        wr(wpd_pkg::REG_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(wpd_pkg::REG_IRQ_STATUS, 32'h2);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h0);
        chk_irq(1'b0);
        rnd = $random(seed);
        wr(wpd_pkg::REG_IRQ_MASK, rnd);
        rd(wpd_pkg::REG_IRQ_MASK, {30'h0, rnd[1:0]});
        wr(wpd_pkg::REG_IRQ_MASK, 32'h0);
        tdone("edges");
        // clock enable low freezes the filter, so the change counts only after it returns
        ce <= 1'b0;
        pin(1'b1, 12'h0);
        ce <= 1'b1;
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h0);
        repeat (wpd_pkg::FILT_CYCLES + 8) @(posedge clk_sys);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h1);
        pin(1'b0, 12'h0);
        wr(wpd_pkg::REG_IRQ_STATUS, 32'h3);
        tdone("clock enable");
        // disabled function, level across every mode
        wr(wpd_pkg::REG_CTRL, 32'h0);
        pin(1'b1, 12'h0);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h0);
        for (int m = 0; m < 8; m++) begin
            setm(wpd_pkg::wpd_mode_t'(m));
            rd(wpd_pkg::REG_LEVEL, (sbc_mode inside {wpd_pkg::MODE_NORMAL, wpd_pkg::MODE_STOP,
                wpd_pkg::MODE_SWFLASH}) ? 32'h1 : 32'h0);
        end
        setm(wpd_pkg::MODE_NORMAL);
        tdone("level");
        // undervoltage hides the edge
        wr(wpd_pkg::REG_CTRL, 32'h1);
        uv_off <= 1'b1;
        pin(1'b0, 12'h0);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h0);
        uv_off <= 1'b0;
        tdone("undervoltage");
        // sleep exit by edge, by pending flag and by flag set in the handover
        setm(wpd_pkg::MODE_SLEEP);
        pulse_q.push_back(2'b01);
        pin(1'b1, 12'h0);
        setm(wpd_pkg::MODE_NORMAL);
        rd(wpd_pkg::REG_IRQ_STATUS, 32'h0);
        pin(1'b0, 12'h0);
        pulse_q.push_back(2'b01);
        setm(wpd_pkg::MODE_SLEEP);
        setm(wpd_pkg::MODE_NORMAL);
        wr(wpd_pkg::REG_IRQ_STATUS, 32'h3);
        setm(wpd_pkg::MODE_INIT);
        sleep_transition <= 1'b1;
        pin(1'b1, 12'h0);
        sleep_transition <= 1'b0;
        pulse_q.push_back(2'b01);
        setm(wpd_pkg::MODE_SLEEP);
        setm(wpd_pkg::MODE_NORMAL);
        wr(wpd_pkg::REG_IRQ_STATUS, 32'h3);
        wr(wpd_pkg::REG_CTRL, 32'h0);
        setm(wpd_pkg::MODE_SLEEP);
        pin(1'b0, 12'h0);
        setm(wpd_pkg::MODE_FAILSAFE);
        pulse_q.push_back(2'b10);
        pin(1'b1, 12'h0);
        setm(wpd_pkg::MODE_NORMAL);
        chk(pulse_q.size(), 32'h0);
        chk(rd_q.size(), 32'h0);
        tdone("sleep and fail-safe");
        end_sim();
    end
endmodule
`default_nettype wire
